/* verilog/ppos_top.sv */
// Purpose: downstream port power, overcurrent qualification and port split
// Assumes: six downstream ports, index n-1 for port n; 50 MHz clock
// Notes:   sense pins are open drain, pull-up enable driven alongside
//
// Operation
// (RULE1) double-pulse window is 8 bits in 1 ms steps, reset 20 ms
// (RULE2) software never writes zero to window or lockout registers
// (RULE3) overcurrent ignored for lockout time after power-on, 1 ms steps, reset 10 ms
// (RULE4) one combined pin per port; driven low while port power is off
// (RULE5) power on: low driver off, pull-up on, pin open drain and sensed
// (RULE6) low on an enabled port pin from an open fuse means overcurrent
// (RULE7) poly-fuse setups set power-on-to-good descriptor fields to zero
// (RULE8) only ports 5 and 6 can be separated; other requests do nothing
// (RULE9) separated: combined pin powers USB 2.0 half, superspeed pin the other
// (RULE10) superspeed power pin is output only, never sensed
// (RULE11) port 5 select: 0x42 option A, 0x05 option B
// (RULE12) port 6 select: 0x06 option A, 0x04 option B
// (RULE13) per-port enable resets zero; bit 5 port 5, bit 6 port 6
// (RULE14) global enable bit 0 resets zero and gates the whole feature
// (RULE15) configuration written during hub configuration stage
// (RULE16) enabled pin sampled; low for programmed single width flags overcurrent
// (RULE17) two separate low groups within the window flag overcurrent
// (RULE18) ganged: one shared pin, its overcurrent flags every port
// (RULE19) 1 ms tick drives timers; lockout restarts at each power-on
// (RULE20) flag held until hub clears it; event raised when it sets
`timescale 1ns/1ps
`default_nettype none
`include "ppos_defs.svh"
module ppos_top
    import ppos_pkg::*;
#(
    parameter int MS_CYCLES = `PPOS_TICK_NS / `PPOS_CLK_NS
) (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [15:0] cfg_addr_i,
    input  wire logic [7:0]  cfg_wdata_i,
    output logic      [7:0]  cfg_rdata_o,
    input  wire logic        gang_mode_i,
    input  wire logic [5:0]  port_power_on_i,
    input  wire logic [5:0]  ss_power_on_i,
    input  wire logic [5:0]  oc_clear_i,
    input  wire logic [5:0]  port_power_sense_pin_i,
    output logic      [5:0]  port_power_sense_pin_o,
    output logic      [5:0]  port_power_sense_pin_oe_o,
    output logic      [5:0]  port_power_sense_pin_pu_o,
    input  wire logic        shared_power_pin_i,
    output logic             shared_power_pin_o,
    output logic             shared_power_pin_oe_o,
    output logic             shared_power_pin_pu_o,
    output logic      [3:0]  superspeed_power_pin_o,
    output logic      [3:0]  superspeed_power_pin_oe_o,
    output logic      [1:0]  split_active_o,
    output logic      [5:0]  oc_flag_o,
    output logic      [5:0]  oc_event_o
);

    // configuration registers
    ppos_byte_t ignore_time_r, ignore_time_nxt;
    ppos_byte_t min_width_r, min_width_nxt;
    ppos_byte_t dbl_window_r, dbl_window_nxt;
    ppos_byte_t port_sep_r, port_sep_nxt;
    ppos_byte_t global_sep_r, global_sep_nxt;
    ppos_byte_t p5_sel_r, p5_sel_nxt;
    ppos_byte_t p6_sel_r, p6_sel_nxt;
    ppos_byte_t rdata_r, rdata_nxt;

    always_comb begin
        ignore_time_nxt = ignore_time_r;
        min_width_nxt   = min_width_r;
        dbl_window_nxt  = dbl_window_r;
        port_sep_nxt    = port_sep_r;
        global_sep_nxt  = global_sep_r;
        p5_sel_nxt      = p5_sel_r;
        p6_sel_nxt      = p6_sel_r;
        rdata_nxt       = rdata_r;
        if (cfg_wr_i) begin
            unique case (cfg_addr_i)
                `PPOS_ADDR_IGNORE_TIME:   ignore_time_nxt = cfg_wdata_i; // RULE3
                `PPOS_ADDR_MIN_WIDTH:     min_width_nxt = cfg_wdata_i & `PPOS_MASK_MIN_WIDTH;
                `PPOS_ADDR_DBL_WINDOW:    dbl_window_nxt = cfg_wdata_i; // RULE1
                `PPOS_ADDR_PORT_SEP_EN:   port_sep_nxt = cfg_wdata_i & `PPOS_MASK_PORT_SEP_EN; // RULE13
                `PPOS_ADDR_GLOBAL_SEP_EN: global_sep_nxt = cfg_wdata_i & `PPOS_MASK_GLOBAL_SEP_EN; // RULE14
                `PPOS_ADDR_P5_SS_SEL:     p5_sel_nxt = cfg_wdata_i; // RULE11
                `PPOS_ADDR_P6_SS_SEL:     p6_sel_nxt = cfg_wdata_i; // RULE12
                default: begin
                end
            endcase
        end
        if (cfg_rd_i) begin
            unique case (cfg_addr_i)
                `PPOS_ADDR_IGNORE_TIME:   rdata_nxt = ignore_time_r;
                `PPOS_ADDR_MIN_WIDTH:     rdata_nxt = min_width_r;
                `PPOS_ADDR_DBL_WINDOW:    rdata_nxt = dbl_window_r;
                `PPOS_ADDR_PORT_SEP_EN:   rdata_nxt = port_sep_r;
                `PPOS_ADDR_GLOBAL_SEP_EN: rdata_nxt = global_sep_r;
                `PPOS_ADDR_P5_SS_SEL:     rdata_nxt = p5_sel_r;
                `PPOS_ADDR_P6_SS_SEL:     rdata_nxt = p6_sel_r;
                default:                  rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ignore_time_r <= `PPOS_RST_IGNORE_TIME; // RULE3
            min_width_r   <= `PPOS_RST_MIN_WIDTH;
            dbl_window_r  <= `PPOS_RST_DBL_WINDOW; // RULE1
            port_sep_r    <= `PPOS_RST_PORT_SEP_EN; // RULE13
            global_sep_r  <= `PPOS_RST_GLOBAL_SEP_EN; // RULE14
            p5_sel_r      <= `PPOS_RST_P5_SS_SEL;
            p6_sel_r      <= `PPOS_RST_P6_SS_SEL;
            rdata_r       <= 8'h00;
        end else begin
            ignore_time_r <= ignore_time_nxt;
            min_width_r   <= min_width_nxt;
            dbl_window_r  <= dbl_window_nxt;
            port_sep_r    <= port_sep_nxt;
            global_sep_r  <= global_sep_nxt;
            p5_sel_r      <= p5_sel_nxt;
            p6_sel_r      <= p6_sel_nxt;
            rdata_r       <= rdata_nxt;
        end
    end

    // 1 ms tick
    logic [15:0] ms_cnt_r, ms_cnt_nxt;
    logic        tick_r, tick_nxt;

    always_comb begin
        tick_nxt   = 1'b0;
        ms_cnt_nxt = ms_cnt_r + 16'h0001;
        if (ms_cnt_r >= 16'(MS_CYCLES - 1)) begin
            ms_cnt_nxt = 16'h0000;
            tick_nxt   = 1'b1; // RULE19
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ms_cnt_r <= 16'h0000;
            tick_r   <= 1'b0;
        end else begin
            ms_cnt_r <= ms_cnt_nxt;
            tick_r   <= tick_nxt;
        end
    end

    // overcurrent qualifiers: six port pins plus the shared pin
    logic       gang_on;
    logic [6:0] qual_en;
    logic [6:0] qual_pin;
    logic [6:0] qual_oc;

    assign gang_on  = gang_mode_i & (|port_power_on_i);
    assign qual_en  = {gang_on, port_power_on_i & {6{~gang_mode_i}}};
    assign qual_pin = {shared_power_pin_i, port_power_sense_pin_i};

    for (genvar g = 0; g < 7; g++) begin : g_qual
        ppos_oc_qual u_qual (
            .clk_i     (clk_i),
            .arst_n_i  (arst_n_i),
            .tick_i    (tick_r),
            .pwr_en_i  (qual_en[g]),
            .pin_i     (qual_pin[g]),
            .lockout_i (ignore_time_r),
            .window_i  (dbl_window_r),
            .width_i   (min_width_r[3:0]),
            .oc_o      (qual_oc[g])
        );
    end

    // flags, pins and split outputs
    logic [5:0] oc_set;
    logic [5:0] flag_r, flag_nxt;
    logic [5:0] event_r, event_nxt;
    logic [5:0] pin_oe_r, pin_oe_nxt;
    logic [5:0] pin_pu_r, pin_pu_nxt;
    logic       sh_oe_r, sh_oe_nxt;
    logic       sh_pu_r, sh_pu_nxt;
    logic [3:0] ss_r, ss_nxt;
    logic [3:0] ss_oe_r, ss_oe_nxt;
    logic [1:0] split_r, split_nxt;
    logic [3:0] ss_sel;

    always_comb begin
        oc_set    = gang_mode_i ? {6{qual_oc[6]}} : qual_oc[5:0]; // RULE6 RULE18
        flag_nxt  = (flag_r & ~oc_clear_i) | oc_set; // RULE20
        event_nxt = oc_set & ~flag_r; // RULE20
        pin_oe_nxt = ~port_power_on_i; // RULE4
        pin_pu_nxt = port_power_on_i; // RULE5
        sh_oe_nxt  = ~gang_on; // RULE18
        sh_pu_nxt  = gang_on;
        // only ports 5 and 6 have split hardware
        split_nxt[0] = global_sep_r[`PPOS_BIT_GLOBAL_SEP] & port_sep_r[`PPOS_BIT_SEP_P5]; // RULE8
        split_nxt[1] = global_sep_r[`PPOS_BIT_GLOBAL_SEP] & port_sep_r[`PPOS_BIT_SEP_P6]; // RULE14
        ss_sel[0] = split_nxt[0] & (p5_sel_r == `PPOS_SEL_P5_OPT_A); // RULE11
        ss_sel[1] = split_nxt[1] & (p6_sel_r == `PPOS_SEL_P6_OPT_A); // RULE12
        ss_sel[2] = split_nxt[0] & (p5_sel_r == `PPOS_SEL_P5_OPT_B); // RULE11
        ss_sel[3] = split_nxt[1] & (p6_sel_r == `PPOS_SEL_P6_OPT_B); // RULE12
        ss_oe_nxt = ss_sel; // RULE10
        ss_nxt    = ss_sel & {ss_power_on_i[5], ss_power_on_i[4],
                              ss_power_on_i[5], ss_power_on_i[4]}; // RULE9
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flag_r   <= 6'h00;
            event_r  <= 6'h00;
            pin_oe_r <= 6'h3f;
            pin_pu_r <= 6'h00;
            sh_oe_r  <= 1'b1;
            sh_pu_r  <= 1'b0;
            ss_r     <= 4'h0;
            ss_oe_r  <= 4'h0;
            split_r  <= 2'h0;
        end else begin
            flag_r   <= flag_nxt;
            event_r  <= event_nxt;
            pin_oe_r <= pin_oe_nxt;
            pin_pu_r <= pin_pu_nxt;
            sh_oe_r  <= sh_oe_nxt;
            sh_pu_r  <= sh_pu_nxt;
            ss_r     <= ss_nxt;
            ss_oe_r  <= ss_oe_nxt;
            split_r  <= split_nxt;
        end
    end

    // low driver level is always zero
    logic [6:0] drive_low_r;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            drive_low_r <= 7'h00;
        end else begin
            drive_low_r <= 7'h00; // RULE4
        end
    end

    assign cfg_rdata_o               = rdata_r;
    assign port_power_sense_pin_o    = drive_low_r[5:0];
    assign port_power_sense_pin_oe_o = pin_oe_r;
    assign port_power_sense_pin_pu_o = pin_pu_r;
    assign shared_power_pin_o        = drive_low_r[6];
    assign shared_power_pin_oe_o     = sh_oe_r;
    assign shared_power_pin_pu_o     = sh_pu_r;
    assign superspeed_power_pin_o    = ss_r;
    assign superspeed_power_pin_oe_o = ss_oe_r;
    assign split_active_o            = split_r;
    assign oc_flag_o                 = flag_r;
    assign oc_event_o                = event_r;

endmodule
`default_nettype wire

/* verilog/ppos_defs.svh */
// Purpose: constants for downstream port power, overcurrent and split control
// Assumes: 8-bit configuration registers at 16-bit addresses
// Notes:   offsets, field positions, reset values and timing counts
`ifndef PPOS_DEFS_SVH
`define PPOS_DEFS_SVH

// register offsets
`define PPOS_ADDR_IGNORE_TIME     16'h30e1
`define PPOS_ADDR_MIN_WIDTH       16'h30ea
`define PPOS_ADDR_DBL_WINDOW      16'h30eb
`define PPOS_ADDR_PORT_SEP_EN     16'h3c48
`define PPOS_ADDR_GLOBAL_SEP_EN   16'h4141
`define PPOS_ADDR_P5_SS_SEL       16'h416e
`define PPOS_ADDR_P6_SS_SEL       16'h416f

// reset values
`define PPOS_RST_IGNORE_TIME      8'h0a
`define PPOS_RST_DBL_WINDOW       8'h14
`define PPOS_RST_MIN_WIDTH        8'h01
`define PPOS_RST_PORT_SEP_EN      8'h00
`define PPOS_RST_GLOBAL_SEP_EN    8'h00
`define PPOS_RST_P5_SS_SEL        8'h42
`define PPOS_RST_P6_SS_SEL        8'h06

// writable field masks and positions
`define PPOS_MASK_MIN_WIDTH       8'h0f
`define PPOS_MASK_PORT_SEP_EN     8'h60
`define PPOS_MASK_GLOBAL_SEP_EN   8'h01
`define PPOS_BIT_SEP_P5           5
`define PPOS_BIT_SEP_P6           6
`define PPOS_BIT_GLOBAL_SEP       0

// superspeed pin select codes
`define PPOS_SEL_P5_OPT_A         8'h42
`define PPOS_SEL_P5_OPT_B         8'h05
`define PPOS_SEL_P6_OPT_A         8'h06
`define PPOS_SEL_P6_OPT_B         8'h04

// timing
`define PPOS_TICK_NS              1000000
`define PPOS_CLK_NS               20

`endif

/* verilog/ppos_pkg.sv */
// Purpose: shared types for port power and overcurrent control
// Assumes: nothing beyond the constants header
// Notes:   one-hot qualifier states
package ppos_pkg;

    typedef logic [7:0] ppos_byte_t;

    typedef enum logic [2:0] {
        PPOS_QS_OFF   = 3'b001,
        PPOS_QS_LOCK  = 3'b010,
        PPOS_QS_ARMED = 3'b100
    } ppos_qstate_t;

endpackage

/* verilog/ppos_oc_qual.sv */
// Purpose: overcurrent qualifier for one sense pin
// Assumes: tick_i is a one-cycle 1 ms strobe, pin_i synchronous
// Notes:   pulses oc_o per qualifying sample
`timescale 1ns/1ps
`default_nettype none
module ppos_oc_qual
    import ppos_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       tick_i,
    input  wire logic       pwr_en_i,
    input  wire logic       pin_i,
    input  wire logic [7:0] lockout_i,
    input  wire logic [7:0] window_i,
    input  wire logic [3:0] width_i,
    output logic            oc_o
);

    ppos_qstate_t state_r, state_nxt;
    logic [7:0]   lock_r, lock_nxt;
    logic [7:0]   win_r, win_nxt;
    logic [3:0]   low_r, low_nxt;
    logic         first_r, first_nxt;
    logic         prev_r, prev_nxt;
    logic         oc_r, oc_nxt;

    always_comb begin
        state_nxt = state_r;
        lock_nxt  = lock_r;
        win_nxt   = win_r;
        low_nxt   = low_r;
        first_nxt = first_r;
        prev_nxt  = pin_i;
        oc_nxt    = 1'b0;
        unique case (state_r)
            PPOS_QS_OFF: begin
                if (pwr_en_i) begin
                    state_nxt = PPOS_QS_LOCK; // RULE19
                    lock_nxt  = lockout_i;
                end
            end
            PPOS_QS_LOCK: begin
                // pin ignored while locked out
                if (!pwr_en_i) begin
                    state_nxt = PPOS_QS_OFF;
                end else if (tick_i) begin
                    if (lock_r <= 8'h01) begin
                        state_nxt = PPOS_QS_ARMED; // RULE3
                        low_nxt   = 4'h0;
                        first_nxt = 1'b0;
                        prev_nxt  = 1'b1;
                    end else begin
                        lock_nxt = lock_r - 8'h01; // RULE3
                    end
                end
            end
            PPOS_QS_ARMED: begin
                if (!pwr_en_i) begin
                    state_nxt = PPOS_QS_OFF;
                end else begin
                    if (pin_i) begin
                        low_nxt = 4'h0;
                    end else if (tick_i && low_r != 4'hf) begin
                        low_nxt = low_r + 4'h1; // RULE19
                    end
                    if (!pin_i && low_r >= width_i) begin
                        oc_nxt = 1'b1; // RULE16
                    end
                    if (first_r && tick_i) begin
                        if (win_r <= 8'h01) begin
                            first_nxt = 1'b0; // RULE1
                        end else begin
                            win_nxt = win_r - 8'h01; // RULE1
                        end
                    end
                    if (!pin_i && prev_r) begin
                        if (first_r) begin
                            oc_nxt = 1'b1; // RULE17
                        end else begin
                            first_nxt = 1'b1; // RULE1
                            win_nxt   = window_i;
                        end
                    end
                end
            end
            default: begin
                state_nxt = PPOS_QS_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= PPOS_QS_OFF;
            lock_r  <= 8'h00;
            win_r   <= 8'h00;
            low_r   <= 4'h0;
            first_r <= 1'b0;
            prev_r  <= 1'b1;
            oc_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            lock_r  <= lock_nxt;
            win_r   <= win_nxt;
            low_r   <= low_nxt;
            first_r <= first_nxt;
            prev_r  <= prev_nxt;
            oc_r    <= oc_nxt;
        end
    end

    assign oc_o = oc_r;

endmodule
`default_nettype wire

/* dv/ppos_top_monitor.sv */
// Purpose: port power, overcurrent and split checker
// Assumes: bound to ppos_top, one clock domain
// Notes:   lockout bound tracked for port 2 only
`timescale 1ns/1ps
`default_nettype none
`include "ppos_defs.svh"
module ppos_top_monitor
    import ppos_pkg::*;
#(
    parameter int MS_CYCLES = 50000
) (
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic        cfg_wr_i,
    input wire logic [15:0] cfg_addr_i,
    input wire logic [7:0]  cfg_wdata_i,
    input wire logic        gang_mode_i,
    input wire logic [5:0]  port_power_on_i,
    input wire logic [5:0]  ss_power_on_i,
    input wire logic [5:0]  oc_clear_i,
    input wire logic [5:0]  port_power_sense_pin_o,
    input wire logic [5:0]  port_power_sense_pin_oe_o,
    input wire logic [5:0]  port_power_sense_pin_pu_o,
    input wire logic        shared_power_pin_oe_o,
    input wire logic        shared_power_pin_pu_o,
    input wire logic [3:0]  superspeed_power_pin_o,
    input wire logic [3:0]  superspeed_power_pin_oe_o,
    input wire logic [5:0]  oc_flag_o,
    input wire logic [5:0]  oc_event_o
);
    logic [7:0]  lock_r;
    logic [7:0]  lock_nxt;
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;

    // lockout value and cycles since port 2 power-on
    always_comb begin
        lock_nxt = lock_r;
        cnt_nxt  = cnt_r;
        if (cfg_wr_i && cfg_addr_i == `PPOS_ADDR_IGNORE_TIME) begin
            lock_nxt = cfg_wdata_i;
        end
        if (!port_power_on_i[1]) begin
            cnt_nxt = 32'h0;
        end else if (cnt_r != 32'hffffffff) begin
            cnt_nxt = cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock_r <= `PPOS_RST_IGNORE_TIME;
            cnt_r  <= 32'h0;
        end else begin
            lock_r <= lock_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_port2_idle;
        (!gang_mode_i && !port_power_on_i[1]) [*4];
    endsequence
    sequence s_opt_b5_held;
        superspeed_power_pin_oe_o[2] [*2];
    endsequence

    a_pin_low_off: assert property (
        !gang_mode_i |=> port_power_sense_pin_oe_o == ~$past(port_power_on_i)
            && port_power_sense_pin_o == 6'h00)
        else $error("port pin drive does not follow power request");
    a_pullup_on: assert property (
        !gang_mode_i |=> port_power_sense_pin_pu_o == $past(port_power_on_i))
        else $error("port pin pull-up does not follow power request");
    a_event_on_rise: assert property (
        oc_event_o == (oc_flag_o & ~$past(oc_flag_o)))
        else $error("overcurrent event not tied to flag rise");
    a_flag_sticky: assert property (
        (($past(oc_flag_o) & ~$past(oc_clear_i)) & ~oc_flag_o) == 6'h00)
        else $error("overcurrent flag dropped without clear");
    a_ss_exclusive: assert property (
        !(superspeed_power_pin_oe_o[0] && superspeed_power_pin_oe_o[2])
            && !(superspeed_power_pin_oe_o[1] && superspeed_power_pin_oe_o[3]))
        else $error("both pin options driven for one port");
    a_ss_follow: assert property (
        s_opt_b5_held |-> superspeed_power_pin_o[2] == $past(ss_power_on_i[4]))
        else $error("superspeed pin does not follow request");
    a_shared_on: assert property (
        gang_mode_i && port_power_on_i != 6'h00
            |=> shared_power_pin_pu_o && !shared_power_pin_oe_o)
        else $error("shared pin not released in ganged mode");
    a_shared_off: assert property (
        !gang_mode_i |=> shared_power_pin_oe_o && !shared_power_pin_pu_o)
        else $error("shared pin not driven low");
    a_lockout_hold: assert property (
        oc_event_o[1] && !gang_mode_i |-> cnt_r + MS_CYCLES >= lock_r * MS_CYCLES)
        else $error("overcurrent flagged inside lockout");
    a_no_flag_off: assert property (
        s_port2_idle |-> !oc_event_o[1])
        else $error("overcurrent flagged on unpowered port");
endmodule

bind ppos_top ppos_top_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wdata_i(cfg_wdata_i), .gang_mode_i(gang_mode_i),
    .port_power_on_i(port_power_on_i), .ss_power_on_i(ss_power_on_i),
    .oc_clear_i(oc_clear_i), .port_power_sense_pin_o(port_power_sense_pin_o),
    .port_power_sense_pin_oe_o(port_power_sense_pin_oe_o),
    .port_power_sense_pin_pu_o(port_power_sense_pin_pu_o),
    .shared_power_pin_oe_o(shared_power_pin_oe_o),
    .shared_power_pin_pu_o(shared_power_pin_pu_o),
    .superspeed_power_pin_o(superspeed_power_pin_o),
    .superspeed_power_pin_oe_o(superspeed_power_pin_oe_o),
    .oc_flag_o(oc_flag_o), .oc_event_o(oc_event_o)
);
`default_nettype wire

/* dv/ppos_fuse_model.sv */
// Purpose: poly fuse and switch model on each sense pin
// Assumes: fault inputs open the fuse or assert switch sense
// Notes:   released pin without pull-up shows the inverse
`timescale 1ns/1ps
`default_nettype none
module ppos_fuse_model (
    input  wire logic [6:0] drv_i,
    input  wire logic [6:0] oe_i,
    input  wire logic [6:0] pu_i,
    input  wire logic [6:0] fault_i,
    output logic      [6:0] lvl_o
);
    // fault shows at once, no power-good delay
    always_comb begin
        for (int k = 0; k < 7; k++) begin
            if (oe_i[k]) begin
                lvl_o[k] = drv_i[k];
            end else if (fault_i[k]) begin
                lvl_o[k] = 1'b0;
            end else if (pu_i[k]) begin
                lvl_o[k] = 1'b1;
            end else begin
                lvl_o[k] = ~drv_i[k];
            end
        end
    end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Purpose: self-checking bench for port power, overcurrent and split
// Assumes: 1 ms shortened to 10 clock cycles
// Notes:   configuration never writes zero timers
`timescale 1ns/1ps
`default_nettype none
`include "ppos_defs.svh"
module tb_top;
    import ppos_pkg::*;
    logic clk, arst_n, cfg_wr, cfg_rd, gang;
    logic [15:0] cfg_addr;
    logic [7:0] cfg_wdata, cfg_rdata_o;
    logic [5:0] pwr, ss_pwr, clr, fault, pin_o, pin_oe, pin_pu, flag, ev;
    logic sh_fault, sh_o, sh_oe, sh_pu;
    logic [6:0] lvl;
    logic [3:0] ss_o, ss_oe;
    logic [1:0] split;
    int n_errors, n_tests, ev_n[6];

    ppos_top #(.MS_CYCLES(10)) dut (.clk_i(clk), .arst_n_i(arst_n), .cfg_wr_i(cfg_wr),
        .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata),
        .cfg_rdata_o(cfg_rdata_o), .gang_mode_i(gang), .port_power_on_i(pwr),
        .ss_power_on_i(ss_pwr), .oc_clear_i(clr), .port_power_sense_pin_i(lvl[5:0]),
        .port_power_sense_pin_o(pin_o), .port_power_sense_pin_oe_o(pin_oe),
        .port_power_sense_pin_pu_o(pin_pu), .shared_power_pin_i(lvl[6]),
        .shared_power_pin_o(sh_o), .shared_power_pin_oe_o(sh_oe),
        .shared_power_pin_pu_o(sh_pu), .superspeed_power_pin_o(ss_o),
        .superspeed_power_pin_oe_o(ss_oe), .split_active_o(split), .oc_flag_o(flag),
        .oc_event_o(ev));
    ppos_fuse_model u_fuse (.drv_i({sh_o, pin_o}), .oe_i({sh_oe, pin_oe}),
        .pu_i({sh_pu, pin_pu}), .fault_i({sh_fault, fault}), .lvl_o(lvl));

    always #10 clk = ~clk;
    always @(posedge clk) for (int k = 0; k < 6; k++) if (ev[k] === 1'b1) ev_n[k]++;

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        cyc(1);
        chk(cfg_rdata_o, exp);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        fault <= m;
        repeat (2) @(posedge clk);
        fault <= 6'h00;
    endtask
    task automatic wait_flag(input logic [5:0] m, input int bound);
        for (int i = 0; i < bound && (flag & m) !== m; i++) cyc(1);
        chk(8'(flag & m), 8'(m));
        if ((flag & m) !== m) wrap_up();
    endtask
    task automatic clear(input logic [5:0] m);
        @(posedge clk);
        clr <= m;
        @(posedge clk);
        clr <= 6'h00;
        cyc(2);
    endtask

    task automatic t_reset_regs();
        rdc(`PPOS_ADDR_IGNORE_TIME, 8'h0a);
        rdc(`PPOS_ADDR_DBL_WINDOW, 8'h14);
        rdc(`PPOS_ADDR_PORT_SEP_EN, 8'h00);
        rdc(`PPOS_ADDR_GLOBAL_SEP_EN, 8'h00);
        chk(8'(pin_oe), 8'h3f);
        chk(8'(pin_pu), 8'h00);
    endtask
    task automatic t_reg_masks();
        wr(`PPOS_ADDR_PORT_SEP_EN, 8'hff);
        rdc(`PPOS_ADDR_PORT_SEP_EN, 8'h60);
        wr(`PPOS_ADDR_GLOBAL_SEP_EN, 8'hff);
        rdc(`PPOS_ADDR_GLOBAL_SEP_EN, 8'h01);
        wr(16'h1234, 8'h55);
        rdc(16'h1234, 8'h00);
        wr(`PPOS_ADDR_IGNORE_TIME, 8'h03);
        rdc(`PPOS_ADDR_IGNORE_TIME, 8'h03);
        wr(`PPOS_ADDR_DBL_WINDOW, 8'h05);
        rdc(`PPOS_ADDR_DBL_WINDOW, 8'h05);
        wr(`PPOS_ADDR_GLOBAL_SEP_EN, 8'h00);
    endtask
    task automatic t_lockout();
        @(posedge clk);
        fault <= 6'h02;
        @(posedge clk);
        pwr <= 6'h02;
        cyc(3);
        chk(8'(pin_oe[1]), 8'h00);
        chk(8'(pin_pu[1]), 8'h01);
        cyc(15);
        chk(8'(flag[1]), 8'h00);
        wait_flag(6'h02, 60);
        @(posedge clk);
        fault <= 6'h00;
        cyc(4);
        chk(8'(ev_n[1]), 8'h01);
        chk(8'(flag[1]), 8'h01);
        clear(6'h02);
        chk(8'(flag[1]), 8'h00);
    endtask
    task automatic t_double();
        wr(`PPOS_ADDR_MIN_WIDTH, 8'h05);
        @(posedge clk);
        pwr <= 6'h06;
        cyc(40);
        pulse(6'h04);
        cyc(20);
        chk(8'(flag[2]), 8'h00);
        pulse(6'h04);
        wait_flag(6'h04, 10);
        clear(6'h04);
        cyc(60);
        pulse(6'h04);
        cyc(75);
        pulse(6'h04);
        cyc(10);
        chk(8'(flag[2]), 8'h00);
    endtask
    task automatic t_gang();
        @(posedge clk);
        gang <= 1'b1;
        cyc(3);
        chk(8'(sh_pu), 8'h01);
        cyc(40);
        @(posedge clk);
        sh_fault <= 1'b1;
        wait_flag(6'h3f, 60);
        @(posedge clk);
        sh_fault <= 1'b0;
        cyc(4);
        clear(6'h3f);
        @(posedge clk);
        gang <= 1'b0;
    endtask
    task automatic t_split();
        @(posedge clk);
        ss_pwr <= 6'h10;
        wr(`PPOS_ADDR_P5_SS_SEL, 8'h05);
        wr(`PPOS_ADDR_P6_SS_SEL, 8'h04);
        wr(`PPOS_ADDR_PORT_SEP_EN, 8'h60);
        cyc(3);
        chk(8'(split), 8'h00);
        chk(8'(ss_oe), 8'h00);
        wr(`PPOS_ADDR_GLOBAL_SEP_EN, 8'h01);
        cyc(3);
        chk(8'(split), 8'h03);
        chk(8'(ss_oe), 8'h0c);
        chk(8'(ss_o & ss_oe), 8'h04);
        @(posedge clk);
        ss_pwr <= 6'h20;
        pwr <= 6'h16;
        cyc(3);
        chk(8'(ss_o & ss_oe), 8'h08);
        chk(8'(pin_pu[4]), 8'h01);
        wr(`PPOS_ADDR_P5_SS_SEL, 8'h42);
        wr(`PPOS_ADDR_P6_SS_SEL, 8'h06);
        cyc(3);
        chk(8'(ss_oe), 8'h03);
        wr(`PPOS_ADDR_P5_SS_SEL, 8'h00);
        cyc(3);
        chk(8'(ss_oe), 8'h02);
        wr(`PPOS_ADDR_PORT_SEP_EN, 8'h1e);
        cyc(3);
        chk(8'(split), 8'h00);
    endtask

    initial begin
        {clk, arst_n, cfg_wr, cfg_rd, gang, sh_fault} = 6'h00;
        {cfg_addr, cfg_wdata} = 24'h0;
        {pwr, ss_pwr, clr, fault} = 24'h0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_regs();
        t_reg_masks();
        t_lockout();
        t_double();
        t_gang();
        t_split();
        wrap_up();
    end
endmodule
`default_nettype wire
